// file: core/snl_pkg.sv
// Package for the single-pin NRZ byte link: register map, timing and types.
package snl_pkg;
   localparam int unsigned BIT_DIVISOR = 256;
   localparam int unsigned HALF_BIT = BIT_DIVISOR / 2;
   localparam int unsigned SYNC_STAGES = 2;
   localparam logic [7:0] OFS_CTRL = 8'h00;
   localparam logic [7:0] OFS_TXDATA = 8'h04;
   localparam logic [7:0] OFS_RXDATA = 8'h08;
   localparam logic [7:0] OFS_STATUS = 8'h0c;
   localparam logic [7:0] OFS_IRQ_STAT = 8'h10;
   localparam logic [7:0] OFS_IRQ_MASK = 8'h14;
   localparam int unsigned CTRL_RX_EN = 0;
   localparam int unsigned CTRL_TX_GO = 1;
   localparam int unsigned ST_CARRY = 0;
   localparam int unsigned ST_RX_BUSY = 1;
   localparam int unsigned ST_TX_BUSY = 2;
   localparam int unsigned IRQ_RX_DONE = 0;
   localparam int unsigned IRQ_FRAME_ERR = 1;
   localparam int unsigned IRQ_TX_DONE = 2;
   localparam logic [2:0] IRQ_MASK_RESET = 3'h0;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   typedef enum logic [1:0]
   {
      SNL_IDLE = 2'b00,
      SNL_START = 2'b01,
      SNL_DATA = 2'b10,
      SNL_STOP = 2'b11
   } snl_state_t;

   typedef struct packed
   {
      logic [7:0] data;
      logic carry;
      logic done;
   } snl_rx_result_t;
endpackage : snl_pkg

// file: core/snl_link.sv
// Single-pin NRZ byte link with AXI4-Lite register access.
//
// Summary of operation
// - Receiver waits for a low start bit, then takes one whole character.
// - Missing stop bit is a framing error; received byte is unreliable.
// - Carry set on good stop bit, cleared on framing error; byte returned.
// - One bit lasts 256 clock cycles on both ends.
// - Transmitter uses the same NRZ framing and bit rate as receiver.
// - Send and receive never mask interrupts nor service a watchdog.
`timescale 1ns/1ps
module snl_link
   import snl_pkg::*;
#(
   parameter int unsigned DIVISOR = BIT_DIVISOR
)
(
   input wire logic CORE_CLK,
   input wire logic NRST,
   input wire logic [7:0] S_AXI_AWADDR,
   input wire logic S_AXI_AWVALID,
   output logic S_AXI_AWREADY,
   input wire logic [31:0] S_AXI_WDATA,
   input wire logic [3:0] S_AXI_WSTRB,
   input wire logic S_AXI_WVALID,
   output logic S_AXI_WREADY,
   output logic [1:0] S_AXI_BRESP,
   output logic S_AXI_BVALID,
   input wire logic S_AXI_BREADY,
   input wire logic [7:0] S_AXI_ARADDR,
   input wire logic S_AXI_ARVALID,
   output logic S_AXI_ARREADY,
   output logic [31:0] S_AXI_RDATA,
   output logic [1:0] S_AXI_RRESP,
   output logic S_AXI_RVALID,
   input wire logic S_AXI_RREADY,
   input wire logic SERIAL_LINK_PIN_IN,
   output logic SERIAL_LINK_PIN_OUT,
   output logic SERIAL_LINK_PIN_OE,
   output logic IRQ
);
   // Counter width covering one bit period.
   localparam int unsigned CW = $clog2(DIVISOR) + 1;
   localparam logic [CW-1:0] FULL_CNT = CW'(DIVISOR - 1);
   localparam logic [CW-1:0] HALF_CNT = CW'(DIVISOR / 2 - 1);

   function automatic logic is_ofs(input logic [7:0] a, input logic [7:0] o);
      return a[7:2] == o[7:2];
   endfunction : is_ofs

   logic [SYNC_STAGES-1:0] pin_sync;
   logic pin;
   logic rx_en;
   logic [7:0] tx_byte;
   logic [2:0] irq_stat;
   logic [2:0] irq_mask;
   snl_rx_result_t rx_res;
   snl_state_t rx_state;
   logic [CW-1:0] rx_cnt;
   logic [2:0] rx_bit;
   logic [7:0] rx_shift;
   snl_state_t tx_state;
   logic [CW-1:0] tx_cnt;
   logic [2:0] tx_bit;
   logic [7:0] tx_shift;
   logic aw_held;
   logic w_held;
   logic [7:0] aw_addr;
   logic [31:0] w_data;
   logic [3:0] w_strb;

   // The pin comes from outside; only the second stage is read.
   always_ff @(posedge CORE_CLK or negedge NRST)
   begin
      if (!NRST)
         pin_sync <= '1;
      else
         pin_sync <= {pin_sync[0], SERIAL_LINK_PIN_IN};
   end
   assign pin = pin_sync[SYNC_STAGES-1];

   wire do_write = aw_held && w_held && !S_AXI_BVALID;
   wire do_read = S_AXI_ARVALID && S_AXI_ARREADY;
   wire wr_ctrl = do_write && is_ofs(aw_addr, OFS_CTRL) && w_strb[0];
   wire wr_tx = do_write && is_ofs(aw_addr, OFS_TXDATA) && w_strb[0];
   wire wr_mask = do_write && is_ofs(aw_addr, OFS_IRQ_MASK) && w_strb[0];
   wire rd_irq = do_read && is_ofs(S_AXI_ARADDR, OFS_IRQ_STAT);
   wire wr_hit = is_ofs(aw_addr, OFS_CTRL) || is_ofs(aw_addr, OFS_TXDATA)
      || is_ofs(aw_addr, OFS_IRQ_MASK);
   wire rd_hit = is_ofs(S_AXI_ARADDR, OFS_CTRL) || is_ofs(S_AXI_ARADDR, OFS_TXDATA)
      || is_ofs(S_AXI_ARADDR, OFS_RXDATA) || is_ofs(S_AXI_ARADDR, OFS_STATUS)
      || is_ofs(S_AXI_ARADDR, OFS_IRQ_STAT) || is_ofs(S_AXI_ARADDR, OFS_IRQ_MASK);
   wire tx_go = wr_ctrl && w_data[CTRL_TX_GO] && tx_state == SNL_IDLE;
   wire rx_tick = rx_cnt == '0;
   wire tx_tick = tx_cnt == '0;
   wire rx_done = rx_state == SNL_STOP && rx_tick;
   wire tx_done = tx_state == SNL_STOP && tx_tick;
   wire [2:0] events = {tx_done, rx_done && !pin, rx_done};
   wire [31:0] rd_word = is_ofs(S_AXI_ARADDR, OFS_CTRL) ? {31'h0, rx_en}
      : is_ofs(S_AXI_ARADDR, OFS_TXDATA) ? {24'h0, tx_byte}
      : is_ofs(S_AXI_ARADDR, OFS_RXDATA) ? {24'h0, rx_res.data}
      : is_ofs(S_AXI_ARADDR, OFS_STATUS)
      ? {29'h0, tx_state != SNL_IDLE, rx_state != SNL_IDLE, rx_res.carry}
      : is_ofs(S_AXI_ARADDR, OFS_IRQ_STAT) ? {29'h0, irq_stat}
      : is_ofs(S_AXI_ARADDR, OFS_IRQ_MASK) ? {29'h0, irq_mask} : 32'h0;

   assign S_AXI_AWREADY = !aw_held;
   assign S_AXI_WREADY = !w_held;
   assign S_AXI_ARREADY = !S_AXI_RVALID;
   assign IRQ = |(irq_stat & irq_mask);

   always_ff @(posedge CORE_CLK or negedge NRST)
   begin
      if (!NRST)
      begin
         aw_held <= 1'b0;
         w_held <= 1'b0;
         aw_addr <= 8'h00;
         w_data <= 32'h0;
         w_strb <= 4'h0;
         S_AXI_BVALID <= 1'b0;
         S_AXI_BRESP <= RESP_OKAY;
      end
      else
      begin
         if (S_AXI_AWVALID && !aw_held)
         begin
            aw_held <= 1'b1;
            aw_addr <= S_AXI_AWADDR;
         end
         if (S_AXI_WVALID && !w_held)
         begin
            w_held <= 1'b1;
            w_data <= S_AXI_WDATA;
            w_strb <= S_AXI_WSTRB;
         end
         if (do_write)
         begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            S_AXI_BVALID <= 1'b1;
            S_AXI_BRESP <= wr_hit ? RESP_OKAY : RESP_SLVERR;
         end
         else if (S_AXI_BREADY)
            S_AXI_BVALID <= 1'b0;
      end
   end

   always_ff @(posedge CORE_CLK or negedge NRST)
   begin
      if (!NRST)
      begin
         S_AXI_RVALID <= 1'b0;
         S_AXI_RDATA <= 32'h0;
         S_AXI_RRESP <= RESP_OKAY;
      end
      else if (do_read)
      begin
         S_AXI_RVALID <= 1'b1;
         S_AXI_RRESP <= rd_hit ? RESP_OKAY : RESP_SLVERR;
         S_AXI_RDATA <= rd_word;
      end
      else if (S_AXI_RREADY)
         S_AXI_RVALID <= 1'b0;
   end

   // A new event wins over the clear-on-read in the same cycle.
   always_ff @(posedge CORE_CLK or negedge NRST)
   begin
      if (!NRST)
      begin
         rx_en <= 1'b0;
         tx_byte <= 8'h00;
         irq_mask <= IRQ_MASK_RESET;
         irq_stat <= 3'h0;
      end
      else
      begin
         if (wr_ctrl)
            rx_en <= w_data[CTRL_RX_EN];
         if (wr_tx && tx_state == SNL_IDLE)
            tx_byte <= w_data[7:0];
         if (wr_mask)
            irq_mask <= w_data[2:0];
         irq_stat <= (rd_irq ? 3'h0 : irq_stat) | events;
      end
   end

   always_ff @(posedge CORE_CLK or negedge NRST)
   begin
      if (!NRST)
      begin
         rx_state <= SNL_IDLE;
         rx_cnt <= '0;
         rx_bit <= 3'h0;
         rx_shift <= 8'h00;
      end
      else
      begin
         rx_cnt <= rx_tick ? FULL_CNT : rx_cnt - CW'(1);
         case (rx_state)
            SNL_IDLE:
            begin
               if (rx_en && !pin)
               begin
                  rx_state <= SNL_START;
                  rx_cnt <= HALF_CNT;
               end
            end
            SNL_START:
            begin
               if (rx_tick)
                  rx_state <= pin ? SNL_IDLE : SNL_DATA;
               rx_bit <= 3'h0;
            end
            SNL_DATA:
            begin
               if (rx_tick)
               begin
                  rx_shift <= {pin, rx_shift[7:1]};
                  rx_bit <= rx_bit + 3'h1;
                  if (rx_bit == 3'h7)
                     rx_state <= SNL_STOP;
               end
            end
            SNL_STOP:
               if (rx_tick)
                  rx_state <= SNL_IDLE;
            default:
               rx_state <= SNL_IDLE;
         endcase
      end
   end

   always_ff @(posedge CORE_CLK or negedge NRST)
   begin
      if (!NRST)
         rx_res <= '0;
      else if (rx_done)
      begin
         rx_res.data <= rx_shift;
         rx_res.carry <= pin;
         rx_res.done <= 1'b1;
      end
   end

   // bit timing and same framing on send
   always_ff @(posedge CORE_CLK or negedge NRST)
   begin
      if (!NRST)
      begin
         tx_state <= SNL_IDLE;
         tx_cnt <= '0;
         tx_bit <= 3'h0;
         tx_shift <= 8'h00;
      end
      else
      begin
         tx_cnt <= tx_tick ? FULL_CNT : tx_cnt - CW'(1);
         case (tx_state)
            SNL_IDLE:
            begin
               if (tx_go)
               begin
                  tx_state <= SNL_START;
                  tx_cnt <= FULL_CNT;
                  tx_shift <= tx_byte;
                  tx_bit <= 3'h0;
               end
            end
            SNL_START:
               if (tx_tick)
                  tx_state <= SNL_DATA;
            SNL_DATA:
            begin
               if (tx_tick)
               begin
                  tx_shift <= {1'b0, tx_shift[7:1]};
                  tx_bit <= tx_bit + 3'h1;
                  if (tx_bit == 3'h7)
                     tx_state <= SNL_STOP;
               end
            end
            SNL_STOP:
               if (tx_tick)
                  tx_state <= SNL_IDLE;
            default:
               tx_state <= SNL_IDLE;
         endcase
      end
   end

   // pin released outside a send, data latch stays low
   assign SERIAL_LINK_PIN_OUT = 1'b0;
   // drive low for start and zero bits; ones float high via pull-up
   assign SERIAL_LINK_PIN_OE = (tx_state == SNL_START)
      || (tx_state == SNL_DATA && !tx_shift[0]);

   // a start bit lasts at least eight cycles
   a_tx_bit_len: assert property (@(posedge CORE_CLK) disable iff (!NRST)
      (tx_state == SNL_START && $past(tx_state) == SNL_IDLE) |->
      (tx_state == SNL_START) [*8])
      else $error("Start bit ended too early.");
   // idle transmitter leaves the pin released
   a_tx_idle_pin: assert property (@(posedge CORE_CLK) disable iff (!NRST)
      (tx_state == SNL_IDLE || tx_state == SNL_STOP) |-> !SERIAL_LINK_PIN_OE)
      else $error("Pin driven outside a character.");
   // start bit drives the pin low
   a_tx_start_low: assert property (@(posedge CORE_CLK) disable iff (!NRST)
      tx_state == SNL_START |-> SERIAL_LINK_PIN_OE && !SERIAL_LINK_PIN_OUT)
      else $error("Start bit not low.");
   a_rx_carry: assert property (@(posedge CORE_CLK) disable iff (!NRST)
      rx_done |=> rx_res.carry == $past(pin))
      else $error("Carry does not follow stop bit.");
   a_rx_frame_err: assert property (@(posedge CORE_CLK) disable iff (!NRST)
      (rx_done && !pin) |=> irq_stat[IRQ_FRAME_ERR])
      else $error("Framing error not flagged.");
   // idle receiver leaves only on a low pin
   a_rx_wait_start: assert property (@(posedge CORE_CLK) disable iff (!NRST)
      (rx_state == SNL_IDLE && pin) |=> rx_state == SNL_IDLE)
      else $error("Receiver left idle without a start bit.");
   // transmit sequence leads to stop then idle
   a_tx_seq: assert property (@(posedge CORE_CLK) disable iff (!NRST)
      (tx_state == SNL_STOP && tx_tick) |=> tx_state == SNL_IDLE && irq_stat[IRQ_TX_DONE])
      else $error("Transmit did not finish properly.");
   // completion shows on the interrupt when unmasked
   a_irq_level: assert property (@(posedge CORE_CLK) disable iff (!NRST)
      (irq_stat[IRQ_RX_DONE] && irq_mask[IRQ_RX_DONE]) |-> IRQ)
      else $error("Unmasked status did not raise interrupt.");
endmodule : snl_link

// file: verification/snl_host.sv
// Host serial port model sharing the pulled-up link wire with the device.
`timescale 1ns/1ps
module snl_host #(
   parameter int unsigned DIV = 16
)
(
   input wire logic core_clk,
   input wire logic dev_oe,
   input wire logic dev_out,
   output logic line
);
   logic host_low = 1'b0;
   logic [7:0] got_byte = 8'h00;
   logic got_stop = 1'b0;
   int got_count = 0;
   int zero_run = 0;
   assign line = !(host_low || (dev_oe && !dev_out));
   task automatic send(input logic [7:0] b, input logic stop_ok);
      logic [8:0] f;
      f = {b, 1'b0};
      for (int i = 0; i < 9; i++)
      begin
         host_low <= !f[i];
         repeat (DIV) @(posedge core_clk);
      end
      // A bad stop bit is released early so the false start that follows it fails its mid-bit check.
      host_low <= !stop_ok;
      repeat (DIV * 3 / 4) @(posedge core_clk);
      host_low <= 1'b0;
      repeat (DIV + DIV / 4) @(posedge core_clk);
   endtask : send
   always
   begin
      @(posedge core_clk iff dev_oe === 1'b1);
      repeat (DIV / 2) @(posedge core_clk);
      for (int i = 0; i < 8; i++)
      begin
         repeat (DIV) @(posedge core_clk);
         got_byte[i] = line;
      end
      repeat (DIV) @(posedge core_clk);
      got_stop = line;
      got_count++;
   end
   // length of each driven low run
   always
   begin
      @(posedge core_clk iff dev_oe === 1'b1);
      zero_run = 1;
      @(posedge core_clk);
      while (dev_oe === 1'b1)
      begin
         zero_run++;
         @(posedge core_clk);
      end
   end
endmodule : snl_host

// file: verification/single_pin_nrz_byte_link_test.sv
// Self-checking testbench of the single-pin byte link.
`timescale 1ns/1ps
module single_pin_nrz_byte_link_test;
   import snl_pkg::*;
   localparam int unsigned DIV = 16;
   logic core_clk = 1'b0;
   logic nrst = 1'b0;
   logic [7:0] awaddr = 8'h00;
   logic [7:0] araddr = 8'h00;
   logic [31:0] wdata = 32'h0;
   logic awvalid = 1'b0;
   logic wvalid = 1'b0;
   logic bready = 1'b0;
   logic arvalid = 1'b0;
   logic rready = 1'b0;
   logic awready, wready, bvalid, arready, rvalid, pout, oe, irq, line;
   logic [1:0] bresp, rresp, resp;
   logic [31:0] rdata, rd;
   int bad_count = 0;
   int checks_done = 0;
   int cycles = 0;

   always #2 core_clk = ~core_clk;

   snl_link #(.DIVISOR(DIV)) snl_link_i (.CORE_CLK(core_clk), .NRST(nrst),
      .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready),
      .S_AXI_WDATA(wdata), .S_AXI_WSTRB(4'hf), .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready),
      .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
      .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready),
      .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready),
      .SERIAL_LINK_PIN_IN(line), .SERIAL_LINK_PIN_OUT(pout), .SERIAL_LINK_PIN_OE(oe),
      .IRQ(irq));
   snl_host #(.DIV(DIV)) snl_host_i (.core_clk(core_clk), .dev_oe(oe), .dev_out(pout),
      .line(line));

   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      checks_done++;
      if (got !== exp)
      begin
         bad_count++;
         $display("[ERR] %s expected %h seen %h", what, exp, got);
      end
   endtask : chk

   task automatic print_verdict();
      $display("Comparisons %0d, mismatches %0d", checks_done, bad_count);
      if (bad_count == 0 && checks_done > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask : print_verdict

   task automatic axi_write(input logic [7:0] a, input logic [31:0] d);
      logic aw_ok;
      logic w_ok;
      aw_ok = 1'b0;
      w_ok = 1'b0;
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      while (!(aw_ok && w_ok))
      begin
         @(posedge core_clk);
         aw_ok = aw_ok || awready;
         w_ok = w_ok || wready;
         awvalid <= !aw_ok;
         wvalid <= !w_ok;
      end
      do @(posedge core_clk); while (bvalid !== 1'b1);
      resp = bresp;
      bready <= 1'b0;
      @(posedge core_clk);
   endtask : axi_write

   task automatic axi_read(input logic [7:0] a);
      logic ar_ok;
      ar_ok = 1'b0;
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      while (!ar_ok)
      begin
         @(posedge core_clk);
         ar_ok = arready;
         arvalid <= !ar_ok;
      end
      do @(posedge core_clk); while (rvalid !== 1'b1);
      rd = rdata;
      resp = rresp;
      rready <= 1'b0;
      @(posedge core_clk);
   endtask : axi_read

   task automatic rchk(input string what, input logic [7:0] a, input logic [31:0] exp);
      axi_read(a);
      chk(what, exp, rd);
   endtask : rchk

   task automatic wait_irq();
      int n;
      n = 0;
      while (irq !== 1'b1 && n < 20 * DIV)
      begin
         @(posedge core_clk);
         n++;
      end
   endtask : wait_irq

   // Cuts a hang short well beyond the expected run length.
   always @(posedge core_clk)
   begin
      cycles++;
      if (cycles == 20000)
      begin
         bad_count++;
         print_verdict();
      end
   end

   initial
   begin
      repeat (12) @(posedge core_clk);
      nrst <= 1'b1;
      @(posedge core_clk);
      rchk("irq mask reset", OFS_IRQ_MASK, {29'h0, IRQ_MASK_RESET});
      axi_read(8'h20);
      chk("unmapped resp", {30'h0, RESP_SLVERR}, {30'h0, resp});
      axi_write(OFS_IRQ_MASK, 32'h7);
      chk("write resp", {30'h0, RESP_OKAY}, {30'h0, resp});
      axi_write(OFS_TXDATA, 32'ha5);
      // The receiver stays off while sending, or it would take back its own character.
      axi_write(OFS_CTRL, 32'h2);
      wait_irq();
      chk("tx irq", 32'h1, {31'h0, irq});
      chk("tx byte", 32'ha5, {24'h0, snl_host_i.got_byte});
      chk("tx stop", 32'h1, {31'h0, snl_host_i.got_stop});
      chk("tx bit length", DIV, snl_host_i.zero_run);
      chk("pin after tx", 32'h0, {30'h0, oe, pout});
      rchk("tx data kept", OFS_TXDATA, 32'ha5);
      rchk("tx done flag", OFS_IRQ_STAT, 32'h4);
      chk("irq cleared", 32'h0, {31'h0, irq});
      axi_write(OFS_CTRL, 32'h1);
      snl_host_i.send(8'h3c, 1'b1);
      wait_irq();
      rchk("rx done flag", OFS_IRQ_STAT, 32'h1);
      rchk("rx byte", OFS_RXDATA, 32'h3c);
      rchk("rx carry set", OFS_STATUS, 32'h1);
      axi_write(OFS_IRQ_MASK, 32'h0);
      snl_host_i.send(8'hc3, 1'b0);
      chk("masked irq", 32'h0, {31'h0, irq});
      rchk("carry cleared", OFS_STATUS, 32'h0);
      axi_write(OFS_IRQ_MASK, 32'h7);
      @(posedge core_clk);
      chk("unmasked irq", 32'h1, {31'h0, irq});
      rchk("framing flags", OFS_IRQ_STAT, 32'h3);
      rchk("unreliable byte", OFS_RXDATA, 32'hc3);
      print_verdict();
   end
endmodule : single_pin_nrz_byte_link_test
